// [src/qc_defs.vh]
// Constants for the dual quadrature up/down counter block.
// Assumes a single 10 MHz clock and an AXI4-Lite register port.
//
// How it works
// [R01] With gating set the enable input is obeyed; else it is ignored.
// [R02] Two independent counters step every clock, not per program scan.
// [R03] Counter one takes inputs 1 and 2; counter two takes inputs 3 and 4.
// [R04] Both rising and falling edges of both channels are examined.
// [R05] The encoder supplies 1:1 square waves with B a quarter period from A.
// [R06] A edge then matching B edge adds one, on rising and falling pairs.
// [R07] When B leads A each edge pair subtracts one; value shown on output.
// [R08] A load pulse copies the preset into the count; flags follow at once.
// [R09] While clear is high the count is zero and the zero flag set.
// [R10] High-limit flag is set while count is at or above the upper threshold; reset clears it until the first edge after release.
// [R11] Low-limit flag is set while count is at or below the lower threshold; reset clears it until the first edge after release.
// [R12] Zero flag is set exactly when the count equals zero; reset clears it until the first edge after release.
// [R13] Range flag marks a count step that would leave the 32-bit range.
// [R14] Retained counts sit in four bytes kept over stop and power loss.
// [R15] A retained counter restarting in run resumes from the kept value.
// [R16] Count, thresholds and preset are signed 32-bit values.
// [R17] On overflow the range flag pulses one cycle and the count holds.
// [R18] With the enable honoured, high activates counting and low stops it.
// [R19] Both channels pass two-stage synchronisers before edge detection.
// [R20] Clear wins over load when both are active in one cycle.
`ifndef QC_DEFS_VH
`define QC_DEFS_VH

// ----------
// Register map, word codes and byte addresses
// ----------
`define QC_AW            8
`define QC_BANK_BIT      5
`define QC_OFS_CTRL      3'h0
`define QC_OFS_UPPER     3'h1
`define QC_OFS_LOWER     3'h2
`define QC_OFS_PRESET    3'h3
`define QC_OFS_COUNT     3'h4
`define QC_OFS_STATUS    3'h5
`define QC_OFS_RUN       3'h6
`define QC_OFS_NONE      3'h7
`define QC_RUN_ADDR      8'h40

// ----------
// Field positions
// ----------
`define QC_CTRL_GATE     0
`define QC_CTRL_ENABLE   1
`define QC_CTRL_RETAIN   2
`define QC_CTRL_CLEAR    3
`define QC_CTRL_LOAD     4
`define QC_ST_HIGH       0
`define QC_ST_LOW        1
`define QC_ST_ZERO       2
`define QC_ST_RANGE      3

// ----------
// Reset values, count limits and bus answers
// ----------
`define QC_CTRL_RST      4'h0
`define QC_WORD_RST      32'h0000_0000
`define QC_COUNT_MAX     32'h7fff_ffff
`define QC_COUNT_MIN     32'h8000_0000
`define QC_RESP_OKAY     2'h0
`define QC_RESP_SLVERR   2'h2

`endif

// [src/qc_counter.v]
// One quadrature up/down counter with limit flags and retention.
// Assumes raw encoder levels that are asynchronous to i_clk.
`timescale 1ns/10ps
`include "qc_defs.vh"

module qc_counter (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire        i_phase_a,
  input  wire        i_phase_b,
  input  wire        i_gate_en,
  input  wire        i_enable,
  input  wire        i_run,
  input  wire        i_retain,
  input  wire        i_clear,
  input  wire        i_load,
  input  wire [31:0] i_upper,
  input  wire [31:0] i_lower,
  input  wire [31:0] i_preset,
  output reg  [31:0] o_actual_count,
  output reg         o_high_limit_flag,
  output reg         o_low_limit_flag,
  output reg         o_zero_flag,
  output reg         o_range_exceeded_flag
);

  // ----------
  // Synchronisers and edge history
  // ----------
  reg  [1:0]  sync_a;
  reg  [1:0]  sync_b;
  reg         last_a;
  reg         last_b;
  reg         run_d;
  reg  [7:0]  nv_mem [0:3];
  reg  [31:0] next_count;
  reg         next_range;
  wire        edge_a = sync_a[1] ^ last_a;
  wire        edge_b = sync_b[1] ^ last_b;
  wire        active = i_gate_en ? i_enable : 1'b1;   // R01 R18
  wire [31:0] nv_word = {nv_mem[3], nv_mem[2], nv_mem[1], nv_mem[0]};
  // A B edge that lands on A's level closes an A-first pair; an A edge
  // landing on B's level closes a B-first pair. Simultaneous edges carry
  // no direction and are dropped.
  wire        step_up = edge_b & ~edge_a & (sync_b[1] == sync_a[1]); // R06
  wire        step_dn = edge_a & ~edge_b & (sync_a[1] == sync_b[1]); // R07

  // The first stage feeds only the second stage.
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      last_a <= 1'b0;
      last_b <= 1'b0;
    end else begin
      sync_a <= {sync_a[0], i_phase_a};                // R19
      sync_b <= {sync_b[0], i_phase_b};                // R19
      last_a <= sync_a[1];                             // R04
      last_b <= sync_b[1];                             // R04
    end
  end

  // ----------
  // Next count
  // ----------
  // Clear first, then load, then the restart resume, then counting.
  always @* begin
    next_count = o_actual_count;
    next_range = 1'b0;
    if (i_clear) begin
      next_count = `QC_WORD_RST;                       // R09 R20
    end else if (i_load) begin
      next_count = i_preset;                           // R08
    end else if (i_run && !run_d) begin
      next_count = i_retain ? nv_word : `QC_WORD_RST;  // R15
    end else if (i_run && active) begin
      if (step_up) begin
        if (o_actual_count == `QC_COUNT_MAX) begin
          next_range = 1'b1;                           // R13 R17
        end else begin
          next_count = o_actual_count + 32'h1;         // R06
        end
      end else if (step_dn) begin
        if (o_actual_count == `QC_COUNT_MIN) begin
          next_range = 1'b1;                           // R13 R17
        end else begin
          next_count = o_actual_count - 32'h1;         // R07
        end
      end
    end
  end

  // ----------
  // Count and flags
  // ----------
  // Flags come from the next value so they agree with the count in the
  // same cycle, including right after a load or clear.
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_actual_count        <= `QC_WORD_RST;
      o_high_limit_flag     <= 1'b0;
      o_low_limit_flag      <= 1'b0;
      o_zero_flag           <= 1'b0;
      o_range_exceeded_flag <= 1'b0;
      run_d                 <= 1'b0;
    end else begin
      run_d                 <= i_run;
      o_actual_count        <= next_count;
      o_high_limit_flag <= $signed(next_count) >= $signed(i_upper); // R10 R16
      o_low_limit_flag <= $signed(next_count) <= $signed(i_lower); // R11 R16
      o_zero_flag           <= (next_count == `QC_WORD_RST);            // R12
      o_range_exceeded_flag <= next_range;                              // R17
    end
  end

  // The kept bytes model non-volatile storage, so reset leaves them alone.
  // They track the count while retained and running, so a stop or a power
  // loss finds the last value already stored.
  always @(posedge i_clk) begin
    if (i_retain && run_d) begin
      nv_mem[0] <= o_actual_count[7:0];                // R14
      nv_mem[1] <= o_actual_count[15:8];               // R14
      nv_mem[2] <= o_actual_count[23:16];              // R14
      nv_mem[3] <= o_actual_count[31:24];              // R14
    end
  end

endmodule

// [src/qc_top.v]
// Dual quadrature counter with an AXI4-Lite register port.
// Assumes one 10 MHz clock, synchronous active-low reset and a master that
// keeps one write and one read outstanding at most.
`timescale 1ns/10ps
`include "qc_defs.vh"

module qc_top (
  input  wire                i_clk,
  input  wire                i_rst_b,
  input  wire                i_encoder1_phase_a_in,
  input  wire                i_encoder1_phase_b_in,
  input  wire                i_encoder2_phase_a_in,
  input  wire                i_encoder2_phase_b_in,
  input  wire [`QC_AW-1:0]   i_s_axi_awaddr,
  input  wire                i_s_axi_awvalid,
  output reg                 o_s_axi_awready,
  input  wire [31:0]         i_s_axi_wdata,
  input  wire [3:0]          i_s_axi_wstrb,
  input  wire                i_s_axi_wvalid,
  output reg                 o_s_axi_wready,
  output reg  [1:0]          o_s_axi_bresp,
  output reg                 o_s_axi_bvalid,
  input  wire                i_s_axi_bready,
  input  wire [`QC_AW-1:0]   i_s_axi_araddr,
  input  wire                i_s_axi_arvalid,
  output reg                 o_s_axi_arready,
  output reg  [31:0]         o_s_axi_rdata,
  output reg  [1:0]          o_s_axi_rresp,
  output reg                 o_s_axi_rvalid,
  input  wire                i_s_axi_rready,
  output wire [31:0]         o_actual_count1,
  output wire [31:0]         o_actual_count2,
  output wire [1:0]          o_high_limit_flag,
  output wire [1:0]          o_low_limit_flag,
  output wire [1:0]          o_zero_flag,
  output wire [1:0]          o_range_exceeded_flag
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Maps a byte address to a register code within a counter bank.
  function [2:0] qc_decode;
    input [`QC_AW-1:0] addr;
    begin
      if (addr[1:0] != 2'h0) begin
        qc_decode = `QC_OFS_NONE;
      end else if (addr == `QC_RUN_ADDR) begin
        qc_decode = `QC_OFS_RUN;
      end else if (addr[7:6] != 2'h0 || addr[4:2] > `QC_OFS_STATUS) begin
        qc_decode = `QC_OFS_NONE;
      end else begin
        qc_decode = addr[4:2];
      end
    end
  endfunction

  // Applies byte enables to a stored word.
  function [31:0] qc_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      k;
    begin
      qc_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          qc_merge[8*k +: 8] = data[8*k +: 8];
        end
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  reg  [3:0]  ctrl      [0:1];
  reg  [31:0] upper     [0:1];
  reg  [31:0] lower     [0:1];
  reg  [31:0] preset    [0:1];
  reg  [1:0]  load_pulse;
  reg  [1:0]  range_seen;
  reg         run_mode;
  wire [31:0] count_w   [0:1];
  wire [1:0]  phase_a = {i_encoder2_phase_a_in, i_encoder1_phase_a_in};
  wire [1:0]  phase_b = {i_encoder2_phase_b_in, i_encoder1_phase_b_in};

  wire        wr_take = i_s_axi_awvalid & i_s_axi_wvalid & ~o_s_axi_bvalid
                        & ~o_s_axi_awready;
  wire        wr_fire = o_s_axi_awready;
  reg  [`QC_AW-1:0] wr_addr;
  reg  [31:0] wr_data;
  reg  [3:0]  wr_strb;
  wire [2:0]  wr_code = qc_decode(wr_addr);
  wire        wr_bank = wr_addr[`QC_BANK_BIT];
  wire        rd_take = i_s_axi_arvalid & ~o_s_axi_rvalid & ~o_s_axi_arready;
  wire [2:0]  rd_code = qc_decode(i_s_axi_araddr);
  wire        rd_bank = i_s_axi_araddr[`QC_BANK_BIT];
  wire [31:0] wr_word = qc_merge(wr_addr[`QC_BANK_BIT] ? preset[1] : preset[0],
                                 wr_data, wr_strb);

  // --------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------
  // Each counter is wired to its own fixed pair of encoder inputs.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : cnt
      qc_counter u_cnt (
        .i_clk                 (i_clk),
        .i_rst_b               (i_rst_b),
        .i_phase_a             (phase_a[g]),                      // R02 R03
        .i_phase_b             (phase_b[g]),                      // R03
        .i_gate_en             (ctrl[g][`QC_CTRL_GATE]),
        .i_enable              (ctrl[g][`QC_CTRL_ENABLE]),
        .i_run                 (run_mode),
        .i_retain              (ctrl[g][`QC_CTRL_RETAIN]),
        .i_clear               (ctrl[g][`QC_CTRL_CLEAR]),
        .i_load                (load_pulse[g]),
        .i_upper               (upper[g]),
        .i_lower               (lower[g]),
        .i_preset              (preset[g]),
        .o_actual_count        (count_w[g]),
        .o_high_limit_flag     (o_high_limit_flag[g]),
        .o_low_limit_flag      (o_low_limit_flag[g]),
        .o_zero_flag           (o_zero_flag[g]),
        .o_range_exceeded_flag (o_range_exceeded_flag[g])
      );
    end
  endgenerate

  assign o_actual_count1 = count_w[0];
  assign o_actual_count2 = count_w[1];

  // --------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------
  // Address and data are taken together in one cycle; the write lands on
  // the following edge and the response rises with it.
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready  <= 1'b0;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= `QC_RESP_OKAY;
      wr_addr         <= {`QC_AW{1'b0}};
      wr_data         <= `QC_WORD_RST;
      wr_strb         <= 4'h0;
    end else begin
      o_s_axi_awready <= wr_take;
      o_s_axi_wready  <= wr_take;
      if (wr_take) begin
        wr_addr <= i_s_axi_awaddr;
        wr_data <= i_s_axi_wdata;
        wr_strb <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (wr_code == `QC_OFS_NONE) ? `QC_RESP_SLVERR
                                                   : `QC_RESP_OKAY;
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register updates from software, plus the sticky range record.
  // A range event in the same cycle as its clear keeps the bit set.
  integer i;
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      run_mode   <= 1'b0;
      load_pulse <= 2'h0;
      range_seen <= 2'h0;
      for (i = 0; i < 2; i = i + 1) begin
        ctrl[i]   <= `QC_CTRL_RST;
        upper[i]  <= `QC_WORD_RST;
        lower[i]  <= `QC_WORD_RST;
        preset[i] <= `QC_WORD_RST;
      end
    end else begin
      load_pulse <= 2'h0;
      if (wr_fire) begin
        case (wr_code)
          `QC_OFS_CTRL: begin
            if (wr_strb[0]) begin
              ctrl[wr_bank] <= wr_data[3:0];                   // R01 R09
              load_pulse[wr_bank] <= wr_data[`QC_CTRL_LOAD];   // R08
            end
          end
          `QC_OFS_UPPER: begin
            upper[wr_bank] <= qc_merge(upper[wr_bank], wr_data, wr_strb);
          end
          `QC_OFS_LOWER: begin
            lower[wr_bank] <= qc_merge(lower[wr_bank], wr_data, wr_strb);
          end
          `QC_OFS_PRESET: begin
            preset[wr_bank] <= wr_word;
          end
          `QC_OFS_STATUS: begin
            if (wr_strb[0] && wr_data[`QC_ST_RANGE]) begin
              range_seen[wr_bank] <= 1'b0;
            end
          end
          `QC_OFS_RUN: begin
            if (wr_strb[0]) begin
              run_mode <= wr_data[0];                          // R15
            end
          end
          default: begin
            run_mode <= run_mode;
          end
        endcase
      end
      for (i = 0; i < 2; i = i + 1) begin
        if (o_range_exceeded_flag[i]) begin
          range_seen[i] <= 1'b1;                               // R17
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------
  // Data is captured with arready, so rvalid rises one edge later.
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= `QC_WORD_RST;
      o_s_axi_rresp   <= `QC_RESP_OKAY;
    end else begin
      o_s_axi_arready <= rd_take;
      if (rd_take) begin
        o_s_axi_rresp <= `QC_RESP_OKAY;
        case (rd_code)
          `QC_OFS_CTRL:   o_s_axi_rdata <= {28'h0, ctrl[rd_bank]};
          `QC_OFS_UPPER:  o_s_axi_rdata <= upper[rd_bank];
          `QC_OFS_LOWER:  o_s_axi_rdata <= lower[rd_bank];
          `QC_OFS_PRESET: o_s_axi_rdata <= preset[rd_bank];
          `QC_OFS_COUNT:  o_s_axi_rdata <= count_w[rd_bank];   // R07
          `QC_OFS_STATUS: o_s_axi_rdata <= {28'h0, range_seen[rd_bank],
                                            o_zero_flag[rd_bank],
                                            o_low_limit_flag[rd_bank],
                                            o_high_limit_flag[rd_bank]};
          `QC_OFS_RUN:    o_s_axi_rdata <= {31'h0, run_mode};
          default: begin
            o_s_axi_rdata <= `QC_WORD_RST;
            o_s_axi_rresp <= `QC_RESP_SLVERR;
          end
        endcase
      end
      if (o_s_axi_arready) begin
        o_s_axi_rvalid <= 1'b1;
      end else if (i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [test/qc_encoder_model.sv]
// Behavioural incremental encoder driving one channel pair of the counter.
// Assumes a free-running i_clk and a one-cycle i_go request from the bench.
`timescale 1ns/10ps

module qc_encoder_model (
  input  wire       i_clk,
  input  wire       i_go,
  input  wire       i_dir,
  input  wire [3:0] i_periods,
  output wire       o_a,
  output wire       o_b,
  output reg        o_busy = 1'h0
);
  reg [1:0] ph = 2'h0;
  reg [5:0] quarters = 6'h00;
  reg [1:0] dwell = 2'h0;

  // ----------
  // Gray phase to levels: 00, 10, 11, 01 gives B a quarter period after A.
  // ----------
  assign o_a = ph[0] ^ ph[1];
  assign o_b = ph[1];

  // Every quarter lasts four cycles, so high and low times stay equal and
  // each level is held long enough for the synchronisers to see it.
  always @(posedge i_clk) begin
    if (i_go) begin
      o_busy <= 1'h1;
      quarters <= {i_periods, 2'h0};
      dwell <= 2'h0;
    end else if (o_busy) begin
      dwell <= dwell + 2'h1;
      if (dwell == 2'h3) begin
        ph <= i_dir ? ph - 2'h1 : ph + 2'h1;
        quarters <= quarters - 6'h01;
        if (quarters == 6'h01) begin
          o_busy <= 1'h0;
        end
      end
    end
  end
endmodule

// [test/qc_checker.sv]
// Concurrent checks on the ports of the dual quadrature counter.
// Assumes binding into qc_top; one clock domain with synchronous reset.
`timescale 1ns/10ps
`include "qc_defs.vh"

module qc_checker (
  input wire        i_clk,
  input wire        i_rst_b,
  input wire        i_encoder1_phase_a_in,
  input wire        i_encoder1_phase_b_in,
  input wire        i_encoder2_phase_a_in,
  input wire        i_encoder2_phase_b_in,
  input wire        o_s_axi_bvalid,
  input wire [31:0] o_actual_count1,
  input wire [31:0] o_actual_count2,
  input wire [1:0]  o_zero_flag,
  input wire [1:0]  o_range_exceeded_flag
);
  reg [7:0] wr_hist;
  reg [7:0] e1_hist;
  reg [7:0] e2_hist;
  reg [1:0] e1_prev;
  reg [1:0] e2_prev;
  wire [1:0] e1_now = {i_encoder1_phase_a_in, i_encoder1_phase_b_in};
  wire [1:0] e2_now = {i_encoder2_phase_a_in, i_encoder2_phase_b_in};

  // ----------
  // History of bus writes and encoder activity.
  // ----------
  // Writes can load, clear or restart a count, so steps are only judged
  // once eight quiet cycles have passed since the last write response.
  always @(posedge i_clk) begin
    wr_hist <= {wr_hist[6:0], o_s_axi_bvalid | ~i_rst_b};
    e1_prev <= e1_now;
    e2_prev <= e2_now;
    e1_hist <= i_rst_b ? {e1_hist[6:0], e1_prev != e1_now} : 8'h00;
    e2_hist <= i_rst_b ? {e2_hist[6:0], e2_prev != e2_now} : 8'h00;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_step1;
    $changed(o_actual_count1) && (wr_hist == 8'h00);
  endsequence
  sequence s_step2;
    $changed(o_actual_count2) && (wr_hist == 8'h00);
  endsequence

  // ----------
  // Assertions.
  // ----------
  AST_ZERO_FLAG: assert property ($past(i_rst_b) |-> o_zero_flag ==
    {o_actual_count2 == 32'h0, o_actual_count1 == 32'h0})
    else $error("zero flag does not match the count");
  AST_UNIT_STEP1: assert property (s_step1 |->
    (o_actual_count1 - $past(o_actual_count1) == 32'h1) ||
    ($past(o_actual_count1) - o_actual_count1 == 32'h1))
    else $error("counter one moved by more than one");
  AST_UNIT_STEP2: assert property (s_step2 |->
    (o_actual_count2 - $past(o_actual_count2) == 32'h1) ||
    ($past(o_actual_count2) - o_actual_count2 == 32'h1))
    else $error("counter two moved by more than one");
  AST_EDGE_CAUSE1: assert property (s_step1 |-> e1_hist != 0)
    else $error("counter one moved without its own encoder edge");
  AST_EDGE_CAUSE2: assert property (s_step2 |-> e2_hist != 8'h00)
    else $error("counter two moved without its own encoder edge");
  AST_RANGE_AT_LIMIT: assert property (o_range_exceeded_flag[0] |->
    (o_actual_count1 == `QC_COUNT_MAX) || (o_actual_count1 == `QC_COUNT_MIN))
    else $error("range flag raised away from the limits");
  AST_RANGE_PULSE: assert property ((o_range_exceeded_flag != 2'h0) |=>
    (o_range_exceeded_flag == 2'h0))
    else $error("range flag lasted more than one cycle");
  AST_RANGE_HOLD: assert property (o_range_exceeded_flag[0] |->
    $stable(o_actual_count1))
    else $error("count changed on a refused step");
endmodule

bind qc_top qc_checker qc_checker_i (
  .i_clk                 (i_clk),
  .i_rst_b               (i_rst_b),
  .i_encoder1_phase_a_in (i_encoder1_phase_a_in),
  .i_encoder1_phase_b_in (i_encoder1_phase_b_in),
  .i_encoder2_phase_a_in (i_encoder2_phase_a_in),
  .i_encoder2_phase_b_in (i_encoder2_phase_b_in),
  .o_s_axi_bvalid        (o_s_axi_bvalid),
  .o_actual_count1       (o_actual_count1),
  .o_actual_count2       (o_actual_count2),
  .o_zero_flag           (o_zero_flag),
  .o_range_exceeded_flag (o_range_exceeded_flag)
);

// [test/quadrature_updown_counter_tb.sv]
// Self-checking bench for the dual quadrature counter.
// Assumes qc_top, two encoder models and the bound checker.
`timescale 1ns/10ps

module quadrature_updown_counter_tb;
  reg         i_clk = 1'h0;
  reg         i_rst_b = 1'h0;
  reg  [7:0]  awaddr = 8'h00;
  reg  [7:0]  araddr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'h0;
  reg         wvalid = 1'h0;
  reg         arvalid = 1'h0;
  reg         go1 = 1'h0;
  reg         go2 = 1'h0;
  reg         dir = 1'h0;
  reg  [3:0]  per = 4'h0;
  reg  [31:0] rd;
  reg         pre_hit = 1'h0;
  wire        a1, b1, a2, b2, busy1, busy2;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp, hi, lo, ze, rg;
  wire [31:0] rdata, cnt1, cnt2;
  integer     error_cnt = 0;
  integer     n_checks = 0;

  always #50 i_clk = ~i_clk;

  qc_encoder_model enc1_i (.i_clk(i_clk), .i_go(go1), .i_dir(dir),
    .i_periods(per), .o_a(a1), .o_b(b1), .o_busy(busy1));
  qc_encoder_model enc2_i (.i_clk(i_clk), .i_go(go2), .i_dir(dir),
    .i_periods(per), .o_a(a2), .o_b(b2), .o_busy(busy2));
  // Byte strobes and the response readies are held at their legal idle.
  qc_top qc_top_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_encoder1_phase_a_in(a1), .i_encoder1_phase_b_in(b1),
    .i_encoder2_phase_a_in(a2), .i_encoder2_phase_b_in(b2),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(1'h1),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(1'h1),
    .o_actual_count1(cnt1), .o_actual_count2(cnt2),
    .o_high_limit_flag(hi), .o_low_limit_flag(lo), .o_zero_flag(ze),
    .o_range_exceeded_flag(rg));

  // Only a load that beat a held clear can show this preset in the count.
  always @(posedge i_clk) if (cnt1 == 32'h5a5) pre_hit <= 1'h1;

  // ----------
  // Shared tasks.
  // ----------
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  task test_done;
    begin
      $display("checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // Each channel is released at the edge where its own ready is seen.
  task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
    integer t;
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      t = 0;
      while (t < 40) begin
        @(posedge i_clk);
        t = t + 1;
        if (awready) awvalid <= 1'h0;
        if (wready) wvalid <= 1'h0;
        if (bvalid) begin
          chk(bresp, er);
          t = 99;
        end
      end
      chk(t, 99);
      repeat (3) @(posedge i_clk);
    end
  endtask

  task axi_rd(input [7:0] a, input [1:0] er, output [31:0] d);
    integer t;
    begin
      araddr <= a;
      arvalid <= 1'h1;
      t = 0;
      while (t < 40) begin
        @(posedge i_clk);
        t = t + 1;
        if (arready) arvalid <= 1'h0;
        if (rvalid) begin
          d = rdata;
          chk(rresp, er);
          t = 99;
        end
      end
      chk(t, 99);
    end
  endtask

  // Whole encoder periods only, so the model always ends at phase zero.
  task move(input ch, input dn, input [3:0] p);
    integer t;
    begin
      dir <= dn;
      per <= p;
      if (ch) go2 <= 1'h1;
      else go1 <= 1'h1;
      @(posedge i_clk);
      go1 <= 1'h0;
      go2 <= 1'h0;
      t = 0;
      @(posedge i_clk);
      while ((busy1 || busy2) && t < 300) begin
        @(posedge i_clk);
        t = t + 1;
      end
      chk(t < 300, 1'h1);
      repeat (6) @(posedge i_clk);
    end
  endtask

  task bus_reset;
    begin
      i_rst_b <= 1'h0;
      repeat (8) @(posedge i_clk);
      i_rst_b <= 1'h1;
      @(posedge i_clk);
    end
  endtask

  // ----------
  // Watchdog and test sequence.
  // ----------
  initial begin
    #(100 * 30000);
    error_cnt = error_cnt + 1;
    test_done;
  end

  initial begin
    bus_reset;
    axi_rd(8'h00, 2'h0, rd);
    chk(rd, 32'h0);
    axi_rd(8'h14, 2'h0, rd);
    chk(rd, 32'h7);
    axi_rd(8'h1c, 2'h2, rd);
    chk(rd, 32'h0);
    axi_wr(8'h38, 32'h1, 2'h2);
    $display("test reset and map done");
    axi_wr(8'h40, 32'h1, 2'h0);
    move(1'h0, 1'h0, 4'h3);
    chk(cnt1, 32'h6);
    chk(cnt2, 32'h0);
    move(1'h0, 1'h1, 4'h1);
    axi_rd(8'h10, 2'h0, rd);
    chk(rd, 32'h4);
    move(1'h1, 1'h1, 4'h2);
    chk(cnt2, 32'hffff_fffc);
    chk(cnt1, 32'h4);
    $display("test counting done");
    axi_wr(8'h04, 32'h4, 2'h0);
    axi_wr(8'h08, 32'h4, 2'h0);
    axi_rd(8'h14, 2'h0, rd);
    chk(rd, 32'h3);
    axi_wr(8'h04, 32'h5, 2'h0);
    axi_wr(8'h08, 32'h3, 2'h0);
    chk(hi[0], 1'h0);
    chk(lo[0], 1'h0);
    axi_wr(8'h28, 32'hffff_fffd, 2'h0);
    chk(lo[1], 1'h1);
    chk(hi[1], 1'h0);
    $display("test thresholds done");
    axi_wr(8'h00, 32'h1, 2'h0);
    move(1'h0, 1'h0, 4'h1);
    chk(cnt1, 32'h4);
    axi_wr(8'h00, 32'h3, 2'h0);
    move(1'h0, 1'h0, 4'h1);
    chk(cnt1, 32'h6);
    chk(hi[0], 1'h1);
    axi_wr(8'h00, 32'h0, 2'h0);
    move(1'h0, 1'h0, 4'h1);
    chk(cnt1, 32'h8);
    $display("test enable done");
    axi_wr(8'h0c, 32'h7fff_fffe, 2'h0);
    axi_wr(8'h00, 32'h10, 2'h0);
    chk(cnt1, 32'h7fff_fffe);
    move(1'h0, 1'h0, 4'h1);
    chk(cnt1, 32'h7fff_ffff);
    axi_rd(8'h14, 2'h0, rd);
    chk(rd, 32'h9);
    axi_wr(8'h14, 32'h8, 2'h0);
    axi_rd(8'h14, 2'h0, rd);
    chk(rd, 32'h1);
    $display("test load and range done");
    axi_wr(8'h0c, 32'h5a5, 2'h0);
    axi_wr(8'h00, 32'h18, 2'h0);
    chk(cnt1, 32'h0);
    chk(pre_hit, 1'h0);
    move(1'h0, 1'h0, 4'h1);
    chk(cnt1, 32'h0);
    chk(ze[0], 1'h1);
    axi_wr(8'h00, 32'h0, 2'h0);
    move(1'h0, 1'h0, 4'h1);
    chk(cnt1, 32'h2);
    $display("test clear done");
    axi_wr(8'h00, 32'h4, 2'h0);
    move(1'h0, 1'h0, 4'h1);
    axi_wr(8'h40, 32'h0, 2'h0);
    axi_wr(8'h40, 32'h1, 2'h0);
    chk(cnt1, 32'h4);
    bus_reset;
    chk(cnt1, 32'h0);
    axi_wr(8'h00, 32'h4, 2'h0);
    axi_wr(8'h40, 32'h1, 2'h0);
    chk(cnt1, 32'h4);
    axi_wr(8'h00, 32'h0, 2'h0);
    axi_wr(8'h40, 32'h0, 2'h0);
    axi_wr(8'h40, 32'h1, 2'h0);
    chk(cnt1, 32'h0);
    $display("test retention done");
    test_done;
  end
endmodule
